// ==== card_model.sv ====
`timescale 1ns/10ps
module card_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [47:0] slot_select,
	input wire io_backplane_pkg::io_op_e slot_command,
	input wire logic mar_load,
	input wire logic [15:0] mar_value,
	input wire logic [5:0] data_code,
	input wire logic [15:0] data_word,
	output logic [15:0] input_bus,
	output logic [47:0] irq_request,
	output logic [47:0] flag_state
);
	logic [47:0] control_r;
	logic [15:0] idle_r;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			control_r <= '0;
			flag_state <= '0;
		end else begin
			case (slot_command)
				io_backplane_pkg::OP_SET_CONTROL: control_r <= control_r | slot_select;
				io_backplane_pkg::OP_CLEAR_CONTROL: control_r <= control_r & ~slot_select;
				io_backplane_pkg::OP_SET_FLAG: flag_state <= flag_state | slot_select;
				io_backplane_pkg::OP_CLEAR_FLAG: flag_state <= flag_state & ~slot_select;
				default: ;
			endcase
			// Serviced card drops its flag
			if (mar_load && mar_value >= 16'h0008 && mar_value <= 16'h0037) begin
				flag_state[mar_value - 16'h0008] <= 1'b0;
			end
		end
	end
	assign irq_request = control_r & flag_state;
	// Released bus shows a changing pattern
	always_ff @(posedge clock) begin
		idle_r <= (idle_r === 16'h5A5A) ? 16'hA5A5 : 16'h5A5A;
	end
	assign input_bus = (data_code >= 6'h08) ? data_word : idle_r;
endmodule

// ==== io_backplane.sv ====
`timescale 1ns/10ps
// What this block does
// R1: Send each instruction command only to the slot named by the select code.
// R2: Commands set or clear a card's control and flag, and test its flag.
// R3: Load and merge instructions pulse the input strobe to every slot.
// R4: Only the addressed card drives the input bus during the strobe.
// R5: Strobed word passes the arithmetic logic into A or B per instruction.
// R6: Output instructions put A or B on the output bus with the output strobe.
// R7: Input, output and result buses are each 16 lines wide.
// R8: Interrupts accepted only after the master enable has been set.
// R9: Each device slot has its own distinct priority level.
// R10: Interrupt phase loads memory address with the device's select code location.
// R11: After the interrupt phase the fetch phase runs the forced location.
// R12: Sixteen slots basic; extenders give 32 or 48 devices.
// R13: Select code is six low instruction bits, decoded to one slot select.
// R14: Select code zero reaches the master interrupt enable, not a slot.
// R15: Codes octal 10 through 67 address the 48 device positions.
// R16: Lower select code means higher interrupt priority.
// R17: Grant only the highest pending request; others wait for later phases.
module io_backplane (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [1:0] extender_count,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire io_backplane_pkg::io_op_e instr_op,
	input wire logic [15:0] instr_word,
	input wire logic [15:0] acc_a,
	input wire logic [15:0] acc_b,
	input wire logic [15:0] input_bus,
	input wire logic [47:0] irq_request,
	input wire logic [47:0] flag_state,
	output logic [47:0] slot_select,
	output io_backplane_pkg::io_op_e slot_command,
	output logic input_strobe,
	output logic output_strobe,
	output logic [15:0] output_bus,
	output logic flag_test_true,
	output logic result_valid,
	input wire logic result_ready,
	output logic [15:0] result_bus,
	output logic result_to_b,
	output logic result_merge,
	output logic mar_load,
	output logic [15:0] mar_value,
	output logic int_system_enabled,
	output io_backplane_pkg::phase_e phase
);
	logic [47:0] irq_s1_r;
	logic [47:0] irq_s2_r;
	logic [47:0] flag_s1_r;
	logic [47:0] flag_s2_r;
	logic [15:0] in_s1_r;
	logic [15:0] in_s2_r;
	logic int_enable_r;
	io_backplane_pkg::phase_e phase_r;
	logic [47:0] slot_select_r;
	io_backplane_pkg::io_op_e slot_command_r;
	logic input_strobe_r;
	logic output_strobe_r;
	logic [15:0] output_bus_r;
	logic flag_test_r;
	logic mar_load_r;
	logic [15:0] mar_value_r;
	logic [47:0] present_mask;
	logic [47:0] pending;
	logic [47:0] served_r;
	logic [5:0] winner_code;
	logic any_pending;
	logic [5:0] code;
	logic fifo_in_ready;
	logic [17:0] fifo_out;
	logic is_input;
	logic is_output;
	logic take;

	// R15 device code window
	function automatic logic [47:0] decode_slot(input logic [5:0] c);
		logic [47:0] v;
		v = '0;
		if (c >= io_backplane_pkg::CODE_FIRST_SLOT && c <= io_backplane_pkg::CODE_LAST_SLOT) begin
			v[6'(c - io_backplane_pkg::CODE_FIRST_SLOT)] = 1'b1;
		end
		return v;
	endfunction

	function automatic logic slot_present(input logic [5:0] idx, input logic [1:0] ext);
		return {2'b00, idx} < (8'd16 + 8'({ext, 4'h0}));
	endfunction

	// R13 select code bits
	assign code = instr_word[5:0];
	assign is_input = instr_op inside {io_backplane_pkg::OP_LOAD_A, io_backplane_pkg::OP_LOAD_B,
		io_backplane_pkg::OP_MERGE_A, io_backplane_pkg::OP_MERGE_B};
	assign is_output = instr_op inside {io_backplane_pkg::OP_OUTPUT_A, io_backplane_pkg::OP_OUTPUT_B};
	assign instr_ready = (phase_r == io_backplane_pkg::PH_FETCH) && !any_pending && fifo_in_ready;
	assign take = instr_valid && instr_ready;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_s1_r <= '0;
			irq_s2_r <= '0;
			flag_s1_r <= '0;
			flag_s2_r <= '0;
			in_s1_r <= io_backplane_pkg::WORD_RESET;
			in_s2_r <= io_backplane_pkg::WORD_RESET;
		end else begin
			irq_s1_r <= irq_request;
			irq_s2_r <= irq_s1_r;
			flag_s1_r <= flag_state;
			flag_s2_r <= flag_s1_r;
			in_s1_r <= input_bus;
			in_s2_r <= in_s1_r;
		end
	end

	// R12 extender sizing
	always_comb begin
		for (int i = 0; i < 48; i++) begin
			present_mask[i] = slot_present(6'(i), extender_count);
		end
	end

	// R17 granted slot waits
	// Synchronised request lags the card by two cycles, so mask the granted slot until it drops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			served_r <= '0;
		end else if ((phase_r == io_backplane_pkg::PH_FETCH) && any_pending) begin
			served_r <= (served_r & irq_s2_r) | decode_slot(winner_code);
		end else begin
			served_r <= served_r & irq_s2_r;
		end
	end

	assign pending = irq_s2_r & ~served_r & present_mask & {48{int_enable_r}};

	// R9 R16 R17 fixed priority, lowest code wins
	always_comb begin
		winner_code = io_backplane_pkg::CODE_RESET;
		any_pending = 1'b0;
		for (int i = 47; i >= 0; i--) begin
			if (pending[i]) begin
				winner_code = 6'(i) + io_backplane_pkg::CODE_FIRST_SLOT;
				any_pending = 1'b1;
			end
		end
	end

	// R14 master enable at code zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			int_enable_r <= 1'b0;
		end else if (take && code == io_backplane_pkg::CODE_ENABLE) begin
			if (instr_op == io_backplane_pkg::OP_SET_CONTROL || instr_op == io_backplane_pkg::OP_SET_FLAG) begin
				int_enable_r <= 1'b1;
			end else if (instr_op == io_backplane_pkg::OP_CLEAR_CONTROL
				|| instr_op == io_backplane_pkg::OP_CLEAR_FLAG) begin
				int_enable_r <= 1'b0;
			end
		end
	end

	// R8 R11 phase sequencing
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= io_backplane_pkg::PH_FETCH;
		end else begin
			case (phase_r)
				io_backplane_pkg::PH_FETCH: begin
					if (any_pending) begin
						phase_r <= io_backplane_pkg::PH_INTERRUPT;
					end else if (take) begin
						phase_r <= io_backplane_pkg::PH_EXEC;
					end
				end
				io_backplane_pkg::PH_EXEC: phase_r <= io_backplane_pkg::PH_FETCH;
				io_backplane_pkg::PH_INTERRUPT: phase_r <= io_backplane_pkg::PH_FETCH;
				default: phase_r <= io_backplane_pkg::PH_FETCH;
			endcase
		end
	end

	// R10 forced address load
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mar_load_r <= 1'b0;
			mar_value_r <= io_backplane_pkg::WORD_RESET;
		end else begin
			mar_load_r <= (phase_r == io_backplane_pkg::PH_FETCH) && any_pending;
			if ((phase_r == io_backplane_pkg::PH_FETCH) && any_pending) begin
				mar_value_r <= {10'h000, winner_code};
			end
		end
	end

	// R1 R2 command routing
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			slot_select_r <= '0;
			slot_command_r <= io_backplane_pkg::OP_NONE;
			flag_test_r <= 1'b0;
		end else if (take) begin
			slot_select_r <= decode_slot(code) & present_mask;
			slot_command_r <= instr_op;
			flag_test_r <= (instr_op == io_backplane_pkg::OP_TEST_FLAG)
				&& |(decode_slot(code) & present_mask & flag_s2_r);
		end else begin
			slot_select_r <= '0;
			slot_command_r <= io_backplane_pkg::OP_NONE;
			flag_test_r <= 1'b0;
		end
	end

	// R3 R6 strobes and output bus
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			input_strobe_r <= 1'b0;
			output_strobe_r <= 1'b0;
			output_bus_r <= io_backplane_pkg::WORD_RESET;
		end else begin
			input_strobe_r <= take && is_input;
			output_strobe_r <= take && is_output;
			if (take && is_output) begin
				output_bus_r <= (instr_op == io_backplane_pkg::OP_OUTPUT_B) ? acc_b : acc_a;
			end
		end
	end

	// R5 R7 input word to result bus via FIFO, tagged with target and merge
	word_fifo #(
		.WIDTH(18),
		.DEPTH(io_backplane_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.in_valid(input_strobe_r),
		.in_ready(fifo_in_ready),
		.in_data({slot_command_r == io_backplane_pkg::OP_LOAD_B || slot_command_r == io_backplane_pkg::OP_MERGE_B,
			slot_command_r == io_backplane_pkg::OP_MERGE_A || slot_command_r == io_backplane_pkg::OP_MERGE_B,
			in_s2_r}),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data(fifo_out)
	);

	assign result_to_b = fifo_out[17];
	assign result_merge = fifo_out[16];
	assign result_bus = fifo_out[15:0];
	assign slot_select = slot_select_r;
	assign slot_command = slot_command_r;
	assign input_strobe = input_strobe_r;
	assign output_strobe = output_strobe_r;
	assign output_bus = output_bus_r;
	assign flag_test_true = flag_test_r;
	assign mar_load = mar_load_r;
	assign mar_value = mar_value_r;
	assign int_system_enabled = int_enable_r;
	assign phase = phase_r;

	// R8 no interrupt while disabled
	AST_NO_IRQ_DISABLED: assert property (@(posedge clock) disable iff (!reset_n) // R8
		!int_enable_r |=> !mar_load_r) else $error("interrupt taken while disabled");
	// R10 interrupt phase loads address
	AST_MAR_IN_INT: assert property (@(posedge clock) disable iff (!reset_n) // R10
		mar_load_r |-> phase_r == io_backplane_pkg::PH_INTERRUPT) else $error("address load outside interrupt");
	sequence int_seq;
		phase_r == io_backplane_pkg::PH_INTERRUPT;
	endsequence
	// R11 fetch after interrupt
	AST_FETCH_AFTER_INT: assert property (@(posedge clock) disable iff (!reset_n) // R11
		int_seq |=> phase_r == io_backplane_pkg::PH_FETCH) else $error("no fetch after interrupt");
	// R1 single slot
	AST_ONE_SLOT: assert property (@(posedge clock) disable iff (!reset_n) // R1
		$onehot0(slot_select_r)) else $error("more than one slot selected");
	// R3 input strobe follows input instruction
	AST_IN_STROBE: assert property (@(posedge clock) disable iff (!reset_n) // R3
		take && is_input |=> input_strobe_r) else $error("input strobe missing");
	// R6 output strobe carries accumulator
	AST_OUT_DATA: assert property (@(posedge clock) disable iff (!reset_n) // R6
		take && instr_op == io_backplane_pkg::OP_OUTPUT_A |=> output_strobe_r && output_bus_r == $past(acc_a))
		else $error("output word wrong");
	// R16 lowest code wins
	AST_PRIORITY: assert property (@(posedge clock) disable iff (!reset_n) // R16
		mar_load_r |-> mar_value_r[5:0] >= io_backplane_pkg::CODE_FIRST_SLOT
			&& |($past(pending) & decode_slot(mar_value_r[5:0]))
			&& ($past(pending) & (decode_slot(mar_value_r[5:0]) - 48'h1)) == '0)
		else $error("bad vector code");
	// R14 code zero selects no slot
	AST_CODE_ZERO: assert property (@(posedge clock) disable iff (!reset_n) // R14
		take && code == io_backplane_pkg::CODE_ENABLE |=> slot_select_r == '0) else $error("code zero hit a slot");
endmodule

// ==== io_backplane_pkg.sv ====
package io_backplane_pkg;
	localparam int WORD_W = 16;
	localparam int CODE_W = 6;
	localparam int NUM_CODES = 64;
	localparam int SLOT_W = 48;
	localparam logic [5:0] CODE_ENABLE = 6'h00;
	localparam logic [5:0] CODE_FIRST_SLOT = 6'h08;
	localparam logic [5:0] CODE_LAST_SLOT = 6'h37;
	localparam int FIFO_DEPTH = 4;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [5:0] CODE_RESET = 6'h00;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_SET_CONTROL,
		OP_CLEAR_CONTROL,
		OP_SET_FLAG,
		OP_CLEAR_FLAG,
		OP_TEST_FLAG,
		OP_LOAD_A,
		OP_LOAD_B,
		OP_MERGE_A,
		OP_MERGE_B,
		OP_OUTPUT_A,
		OP_OUTPUT_B
	} io_op_e;

	typedef enum logic [1:0] {
		PH_FETCH,
		PH_EXEC,
		PH_INTERRUPT
	} phase_e;
endpackage

// ==== io_backplane_transfer_interrupt_bench.sv ====
`timescale 1ns/10ps
module io_backplane_transfer_interrupt_bench;
	logic clock = 0, reset_n = 0, instr_valid = 0, result_ready = 0, hold = 1;
	logic [1:0] extender_count = 2'h3;
	io_backplane_pkg::io_op_e instr_op = io_backplane_pkg::OP_NONE;
	logic [15:0] instr_word = 16'h0000, acc_a = 16'h0000, acc_b = 16'h0000, data_word = 16'h0000;
	logic [5:0] data_code = 6'h00;
	wire logic [15:0] input_bus, output_bus, result_bus, mar_value;
	wire logic [47:0] irq_request, flag_state, slot_select;
	wire io_backplane_pkg::io_op_e slot_command;
	wire io_backplane_pkg::phase_e phase;
	wire logic instr_ready, input_strobe, output_strobe, flag_test_true, result_valid;
	wire logic result_to_b, result_merge, mar_load, int_system_enabled;
	int seed = 84866, n_mismatch = 0, comparisons = 0;
	logic [17:0] exp_q[$];
	logic [5:0] exp_irq[$];
	logic [31:0] rnd;
	always #50 clock = ~clock;
	io_backplane io_backplane_i (.clock(clock), .reset_n(reset_n), .extender_count(extender_count),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op), .instr_word(instr_word),
		.acc_a(acc_a), .acc_b(acc_b), .input_bus(input_bus), .irq_request(irq_request),
		.flag_state(flag_state), .slot_select(slot_select), .slot_command(slot_command),
		.input_strobe(input_strobe), .output_strobe(output_strobe), .output_bus(output_bus),
		.flag_test_true(flag_test_true), .result_valid(result_valid), .result_ready(result_ready),
		.result_bus(result_bus), .result_to_b(result_to_b), .result_merge(result_merge), .mar_load(mar_load),
		.mar_value(mar_value), .int_system_enabled(int_system_enabled), .phase(phase));
	card_model card_model_i (.clock(clock), .reset_n(reset_n), .slot_select(slot_select),
		.slot_command(slot_command), .mar_load(mar_load), .mar_value(mar_value), .data_code(data_code),
		.data_word(data_word), .input_bus(input_bus), .irq_request(irq_request), .flag_state(flag_state));
	function automatic logic [47:0] exp_sel(input logic [5:0] code, input logic [1:0] ext);
		int slots;
		slots = (ext == 2'h0) ? 16 : (ext == 2'h1) ? 32 : 48;
		if (code >= 6'h08 && int'(code) < 8 + slots) return 48'h1 << (code - 6'h08);
		return 48'h0;
	endfunction
	task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic issue(input io_backplane_pkg::io_op_e op, input logic [5:0] code);
		logic [47:0] sel;
		logic is_in, is_out;
		logic [15:0] a, b, w;
		int n;
		is_in = op >= io_backplane_pkg::OP_LOAD_A && op <= io_backplane_pkg::OP_MERGE_B;
		is_out = op >= io_backplane_pkg::OP_OUTPUT_A;
		rnd = $random(seed);
		a = rnd[15:0];
		b = rnd[31:16];
		w = a ^ 16'h3C3C;
		@(posedge clock);
		sel = exp_sel(code, extender_count);
		data_code <= is_in ? code : 6'h00;
		data_word <= w;
		repeat (3) @(posedge clock);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_word <= {b[15:6], code};
		acc_a <= a;
		acc_b <= b;
		for (n = 0; n < 300; n++) begin
			@(negedge clock);
			if (instr_ready === 1'b1) break;
		end
		if (n == 300) check("instr_ready", 1, 0);
		@(posedge clock);
		instr_valid <= 1'b0;
		@(negedge clock);
		check("slot_select", sel, slot_select);
		check("slot_command", op, slot_command);
		check("input_strobe", is_in, input_strobe);
		check("output_strobe", is_out, output_strobe);
		if (is_out) check("output_bus", (op == io_backplane_pkg::OP_OUTPUT_A) ? a : b, output_bus);
		check("flag_test", op == io_backplane_pkg::OP_TEST_FLAG && (flag_state & sel) != 0, flag_test_true);
		if (is_in) exp_q.push_back({op == io_backplane_pkg::OP_LOAD_B || op == io_backplane_pkg::OP_MERGE_B,
			op >= io_backplane_pkg::OP_MERGE_A, w});
	endtask
	always @(posedge clock) begin
		result_ready <= hold ? 1'b0 : 1'(($random(seed) & 3) != 0);
		if (result_valid === 1'b1 && result_ready) begin
			// word lands in the chosen accumulator
			if (exp_q.size() == 0) check("extra result", 0, 1);
			else check("result", exp_q.pop_front(), {result_to_b, result_merge, result_bus});
		end
		if (mar_load === 1'b1) begin
			if (exp_irq.size() == 0) check("extra interrupt", 0, 1);
			else check("mar_value", {10'h000, exp_irq.pop_front()}, mar_value);
			check("phase", io_backplane_pkg::PH_INTERRUPT, phase);
		end
	end
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		hold <= 1'b0;
		for (int c = 1; c < 64; c++) begin
			rnd = $random(seed);
			if (c >= 8 && c < 56) issue(io_backplane_pkg::io_op_e'(6 + rnd[3:0] % 6), 6'(c));
			else issue(io_backplane_pkg::OP_SET_FLAG, 6'(c));
		end
		hold <= 1'b1;
		repeat (4) issue(io_backplane_pkg::OP_LOAD_A, 6'h0A);
		repeat (3) @(negedge clock);
		check("full fifo refuses", 0, instr_ready);
		hold <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			@(posedge clock);
			extender_count <= 2'(e);
			issue(io_backplane_pkg::OP_SET_FLAG, 6'(8 + 16 * e + 15));
			issue(io_backplane_pkg::OP_SET_FLAG, 6'(8 + 16 * e + 16));
			issue(io_backplane_pkg::OP_CLEAR_FLAG, 6'(8 + 16 * e + 15));
		end
		@(posedge clock);
		extender_count <= 2'h3;
		issue(io_backplane_pkg::OP_SET_CONTROL, 6'h0C);
		issue(io_backplane_pkg::OP_SET_FLAG, 6'h0C);
		issue(io_backplane_pkg::OP_SET_CONTROL, 6'h09);
		issue(io_backplane_pkg::OP_SET_FLAG, 6'h09);
		issue(io_backplane_pkg::OP_TEST_FLAG, 6'h09);
		repeat (10) @(posedge clock);
		check("disabled interrupts", 0, exp_irq.size() + mar_load);
		exp_irq.push_back(6'h09);
		exp_irq.push_back(6'h0C);
		issue(io_backplane_pkg::OP_SET_CONTROL, 6'h00);
		check("enable", 1, int_system_enabled);
		for (int n = 0; n < 100 && exp_irq.size() > 0; n++) @(posedge clock);
		issue(io_backplane_pkg::OP_CLEAR_CONTROL, 6'h00);
		check("disable", 0, int_system_enabled);
		for (int n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge clock);
		check("pending", 0, exp_q.size() + exp_irq.size());
		finish_test();
	end
	initial begin
		#(100 * 40000);
		n_mismatch++;
		finish_test();
	end
endmodule

// ==== word_fifo.sv ====
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
